// ==== src/adctsc_pkg.sv ====
// Purpose: constants and types for the converter trigger/start control
// Assumes: apb with 32-bit data, 8-bit registers in the low bits
// Notes: offsets are word aligned byte addresses
package adctsc_pkg;
   // ***************************************
   // register map
   // ***************************************
   localparam logic [7:0] ADR_IRQ_FLAGS = 8'h00;
   localparam logic [7:0] ADR_IRQ_ENABLES = 8'h04;
   localparam logic [7:0] ADR_IRQ_PRIORITY = 8'h08;
   localparam logic [7:0] ADR_RESULT_HIGH = 8'h0C;
   localparam logic [7:0] ADR_RESULT_LOW = 8'h10;
   localparam logic [7:0] ADR_CONTROL_MAIN = 8'h14;
   localparam logic [7:0] ADR_REF_PINS = 8'h18;
   localparam logic [7:0] ADR_FORMAT_CLOCK = 8'h1C;
   localparam logic [7:0] ADR_COMPARE_CTRL = 8'h20;
   // ***************************************
   // fields and reset values
   // ***************************************
   localparam int BIT_DONE_FLAG = 6;
   localparam int BIT_CONV_ON = 0;
   localparam int BIT_GO = 1;
   localparam int BIT_FORMAT_RIGHT = 7;
   localparam logic [7:0] RST_IRQ_PRIORITY = 8'h7F;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [3:0] COMPARE_MODE_TRIGGER = 4'hB;
   localparam logic [7:0] CTRL_MAIN_MASK = 8'h3F;
   localparam logic [7:0] REF_PINS_MASK = 8'h3F;
   localparam logic [7:0] FORMAT_CLOCK_MASK = 8'h87;
   // ***************************************
   // timing
   // ***************************************
   localparam int CONV_PERIODS = 12;
   localparam int ABORT_WAIT_PERIODS = 2;
   localparam int RC_DIVIDE = 64;
   localparam int BITS = 10;

   typedef enum logic [1:0] {
      ADCTSC_IDLE = 2'b00,
      ADCTSC_CONV = 2'b01,
      ADCTSC_WAIT = 2'b11
   } adctsc_state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } adctsc_apb_req_t;
endpackage

// ==== src/adctsc_top.sv ====
// Purpose: start/trigger control, result and flags of a 10-bit converter
// Assumes: sample data arrives from the analog core on the same clock
// Notes: bit period derived from clk_sys by the programmed divider
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - trigger accepted only with compare mode 1011
// - trigger while enabled sets go flag
// - every trigger in compare mode 1011 clears the serving timer
// - disabled converter ignores trigger, timer still cleared
// - conversion lasts twelve bit periods
// - go clear aborts, result unchanged
// - after abort wait two periods, reacquire
module adctsc_top
   import adctsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire adctsc_apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic special_event,
   input wire logic [BITS-1:0] sample_value,
   output logic timer_clear,
   output logic acquire_on,
   output logic [3:0] channel_select,
   output logic converting,
   output logic conversion_done_flag
);
   // ***************************************
   // registers
   // ***************************************
   logic [7:0] irq_flags_ff, irq_enables_ff, irq_priority_ff;
   logic [7:0] result_high_ff, result_low_ff;
   logic [7:0] ctrl_main_ff, ref_pins_ff, format_clock_ff, compare_ctrl_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff, timer_clear_ff, acquire_ff, converting_ff;
   adctsc_state_t state_ff;
   logic [6:0] div_cnt_ff;
   logic [3:0] period_cnt_ff;
   logic event_s1_ff, event_s2_ff, event_s3_ff;

   wire logic wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite & ~pready_ff;
   wire logic rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite & ~pready_ff;
   wire logic [7:0] wdat = apb_req.pwdata[7:0];
   wire logic trig = event_s2_ff & ~event_s3_ff;
   wire logic mode_ok = compare_ctrl_ff[3:0] == COMPARE_MODE_TRIGGER;
   wire logic trig_go = trig & mode_ok & ctrl_main_ff[BIT_CONV_ON];
   wire logic sw_go_clear = wr_acc & (apb_req.paddr == ADR_CONTROL_MAIN) & ~wdat[BIT_GO];

   function automatic logic [6:0] div_limit(input logic [2:0] sel);
      case (sel)
         3'b000: div_limit = 7'd1;
         3'b100: div_limit = 7'd3;
         3'b001: div_limit = 7'd7;
         3'b101: div_limit = 7'd15;
         3'b010: div_limit = 7'd31;
         3'b110: div_limit = 7'd63;
         default: div_limit = 7'(RC_DIVIDE - 1); // rc source modelled as fixed divide
      endcase
   endfunction

   wire logic tick = div_cnt_ff >= div_limit(format_clock_ff[2:0]);
   wire logic last_period = tick & (period_cnt_ff == 4'(CONV_PERIODS - 1));
   wire logic done = (state_ff == ADCTSC_CONV) & last_period & ctrl_main_ff[BIT_GO];
   wire logic abort = (state_ff == ADCTSC_CONV) & ~(ctrl_main_ff[BIT_GO] & ctrl_main_ff[BIT_CONV_ON]);
   wire logic [15:0] result_word = format_clock_ff[BIT_FORMAT_RIGHT] ?
      {6'h00, sample_value} : {sample_value, 6'h00};

   // ***************************************
   // trigger input synchroniser
   // ***************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         event_s1_ff <= 1'b0;
         event_s2_ff <= 1'b0;
         event_s3_ff <= 1'b0;
      end
      else
      begin
         event_s1_ff <= special_event;
         event_s2_ff <= event_s1_ff;
         event_s3_ff <= event_s2_ff;
      end
   end

   // timer cleared on every trigger in compare mode 1011, enabled or not
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         timer_clear_ff <= 1'b0;
      else
         timer_clear_ff <= trig & mode_ok;
   end

   // ***************************************
   // conversion sequencer
   // ***************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_ff <= ADCTSC_IDLE;
         div_cnt_ff <= 7'h00;
         period_cnt_ff <= 4'h0;
      end
      else
      begin
         // divider restarts on abort, else the first wait period would be cut short
         div_cnt_ff <= (tick || state_ff == ADCTSC_IDLE || abort) ? 7'h00 : div_cnt_ff + 7'h01;
         case (state_ff)
            ADCTSC_IDLE:
            begin
               period_cnt_ff <= 4'h0;
               if (ctrl_main_ff[BIT_GO] && ctrl_main_ff[BIT_CONV_ON])
                  state_ff <= ADCTSC_CONV;
            end
            ADCTSC_CONV:
            begin
               if (!ctrl_main_ff[BIT_GO] || !ctrl_main_ff[BIT_CONV_ON])
               begin
                  state_ff <= ADCTSC_WAIT;
                  period_cnt_ff <= 4'h0;
               end
               else if (last_period)
                  state_ff <= ADCTSC_IDLE;
               else if (tick)
                  period_cnt_ff <= period_cnt_ff + 4'h1;
            end
            ADCTSC_WAIT:
            begin
               if (tick && period_cnt_ff == 4'(ABORT_WAIT_PERIODS - 1))
                  state_ff <= ADCTSC_IDLE;
               else if (tick)
                  period_cnt_ff <= period_cnt_ff + 4'h1;
            end
            default: state_ff <= ADCTSC_IDLE;
         endcase
      end
   end

   // sampling switch closed while the converter is on, idle and go is clear
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         acquire_ff <= 1'b0;
         converting_ff <= 1'b0;
      end
      else
      begin
         acquire_ff <= ctrl_main_ff[BIT_CONV_ON] & (state_ff == ADCTSC_IDLE) & ~ctrl_main_ff[BIT_GO];
         converting_ff <= state_ff == ADCTSC_CONV;
      end
   end

   // ***************************************
   // control register; trigger set wins over software clear
   // ***************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         ctrl_main_ff <= RST_ZERO;
      else
      begin
         if (wr_acc && apb_req.paddr == ADR_CONTROL_MAIN)
            ctrl_main_ff <= wdat & CTRL_MAIN_MASK;
         if (done)
            ctrl_main_ff[BIT_GO] <= 1'b0;
         if (trig_go)
            ctrl_main_ff[BIT_GO] <= 1'b1;
      end
   end

   // result pair keeps old value on a go clear abort
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         result_high_ff <= RST_ZERO;
         result_low_ff <= RST_ZERO;
      end
      else if (done && !sw_go_clear)
      begin
         result_high_ff <= result_word[15:8];
         result_low_ff <= result_word[7:0];
      end
      else if (wr_acc && apb_req.paddr == ADR_RESULT_HIGH)
         result_high_ff <= wdat;
      else if (wr_acc && apb_req.paddr == ADR_RESULT_LOW)
         result_low_ff <= wdat;
   end

   // ***************************************
   // flag, enable, priority and config registers
   // ***************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         irq_flags_ff <= RST_ZERO;
      else
      begin
         if (wr_acc && apb_req.paddr == ADR_IRQ_FLAGS)
            irq_flags_ff <= wdat;
         if (done && !sw_go_clear)
            irq_flags_ff[BIT_DONE_FLAG] <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         irq_enables_ff <= RST_ZERO;
         irq_priority_ff <= RST_IRQ_PRIORITY;
         ref_pins_ff <= RST_ZERO;
         format_clock_ff <= RST_ZERO;
         compare_ctrl_ff <= RST_ZERO;
      end
      else if (wr_acc)
      begin
         case (apb_req.paddr)
            ADR_IRQ_ENABLES: irq_enables_ff <= wdat;
            ADR_IRQ_PRIORITY: irq_priority_ff <= wdat;
            ADR_REF_PINS: ref_pins_ff <= wdat & REF_PINS_MASK;
            ADR_FORMAT_CLOCK: format_clock_ff <= wdat & FORMAT_CLOCK_MASK;
            ADR_COMPARE_CTRL: compare_ctrl_ff <= wdat;
            default: ;
         endcase
      end
   end

   // ***************************************
   // apb slave: one wait state, unmapped addresses answer pslverr
   // ***************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
      else
      begin
         pready_ff <= apb_req.psel & apb_req.penable & ~pready_ff;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         if (rd_acc || wr_acc)
         begin
            case (apb_req.paddr)
               ADR_IRQ_FLAGS: prdata_ff[7:0] <= irq_flags_ff;
               ADR_IRQ_ENABLES: prdata_ff[7:0] <= irq_enables_ff;
               ADR_IRQ_PRIORITY: prdata_ff[7:0] <= irq_priority_ff;
               ADR_RESULT_HIGH: prdata_ff[7:0] <= result_high_ff;
               ADR_RESULT_LOW: prdata_ff[7:0] <= result_low_ff;
               ADR_CONTROL_MAIN: prdata_ff[7:0] <= ctrl_main_ff;
               ADR_REF_PINS: prdata_ff[7:0] <= ref_pins_ff;
               ADR_FORMAT_CLOCK: prdata_ff[7:0] <= format_clock_ff;
               ADR_COMPARE_CTRL: prdata_ff[7:0] <= compare_ctrl_ff;
               default: pslverr_ff <= 1'b1;
            endcase
         end
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign timer_clear = timer_clear_ff;
   assign acquire_on = acquire_ff;
   assign channel_select = ctrl_main_ff[5:2];
   assign converting = converting_ff;
   assign conversion_done_flag = irq_flags_ff[BIT_DONE_FLAG];
endmodule
`default_nettype wire

// ==== tb/adctsc_assertions.sv ====
// Purpose: port checks on trigger, conversion and abort timing
// Assumes: control fields shadowed from apb writes at the taken edge
// Notes: abort wait bounds hold for clock select 000 only
`timescale 1ns/1ps
`default_nettype none
module adctsc_assertions
   import adctsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire adctsc_apb_req_t apb_req,
   input wire logic pready,
   input wire logic special_event,
   input wire logic timer_clear,
   input wire logic acquire_on,
   input wire logic converting,
   input wire logic conversion_done_flag
);
   logic wr;
   logic on_ff;
   logic ab_ff;
   logic [3:0] mode_ff;
   logic [2:0] div_ff;
   logic [9:0] cnt_ff;
   int per;
   assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite & ~pready;
   assign per = (div_ff[1:0] == 2'b11) ? 64 : (2 << {div_ff[1:0], div_ff[2]});
   // one process: shadows, abort marker and cycle counter, so split concerns buy nothing here
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         on_ff <= 1'b0;
         ab_ff <= 1'b0;
         mode_ff <= 4'h0;
         div_ff <= 3'h0;
         cnt_ff <= 10'h000;
      end
      else
      begin
         cnt_ff <= converting ? cnt_ff + 10'h001 : 10'h000;
         if (wr && apb_req.paddr == ADR_COMPARE_CTRL)
            mode_ff <= apb_req.pwdata[3:0];
         if (wr && apb_req.paddr == ADR_FORMAT_CLOCK)
            div_ff <= apb_req.pwdata[2:0];
         if (wr && apb_req.paddr == ADR_CONTROL_MAIN)
            on_ff <= apb_req.pwdata[BIT_CONV_ON];
         if (wr && apb_req.paddr == ADR_CONTROL_MAIN && !apb_req.pwdata[BIT_GO] && converting)
            ab_ff <= 1'b1;
         else if (!converting)
            ab_ff <= 1'b0;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_abort_wait;
      !acquire_on [*4] ##1 acquire_on;
   endsequence
   property p_mode_clear;
      $rose(special_event) && mode_ff == COMPARE_MODE_TRIGGER |-> ##[3:5] timer_clear;
   endproperty
   a_mode_clear: assert property (p_mode_clear) else $error("timer clear missing");
   property p_mode_ignore;
      $rose(special_event) && mode_ff != COMPARE_MODE_TRIGGER |-> !timer_clear [*6];
   endproperty
   a_mode_ignore: assert property (p_mode_ignore) else $error("trigger taken in wrong mode");
   property p_start;
      timer_clear && on_ff && !converting |-> ##[0:2] converting;
   endproperty
   a_start: assert property (p_start) else $error("trigger did not start");
   property p_off_ignore;
      timer_clear && !on_ff && !converting |=> !converting [*4];
   endproperty
   a_off_ignore: assert property (p_off_ignore) else $error("disabled converter started");
   property p_length;
      $fell(converting) && !ab_ff |-> cnt_ff == CONV_PERIODS * per;
   endproperty
   a_length: assert property (p_length) else $error("conversion length wrong");
   property p_done;
      $fell(converting) && !ab_ff |-> conversion_done_flag;
   endproperty
   a_done: assert property (p_done) else $error("done flag not set");
   property p_abort_flag;
      $fell(converting) && ab_ff |-> !conversion_done_flag;
   endproperty
   a_abort_flag: assert property (p_abort_flag) else $error("abort set done flag");
   property p_abort_wait;
      $fell(converting) && ab_ff |-> s_abort_wait;
   endproperty
   a_abort_wait: assert property (p_abort_wait) else $error("abort wait wrong");
endmodule
bind adctsc_top adctsc_assertions u_adctsc_assertions (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req),
   .pready(pready), .special_event(special_event), .timer_clear(timer_clear), .acquire_on(acquire_on),
   .converting(converting), .conversion_done_flag(conversion_done_flag));
`default_nettype wire

// ==== tb/adctsc_partner.sv ====
// Purpose: timer and compare match that raise the special event
// Assumes: event level holds until the converter clears the timer
// Notes: an uncleared timer wraps, so events still repeat
`timescale 1ns/1ps
`default_nettype none
module adctsc_partner
#(
   parameter int PER = 100
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic run,
   input wire logic timer_clear,
   output logic special_event,
   output logic [7:0] tmr_ff
);
   always_ff @(posedge clk_sys)
   begin
      if (rst || timer_clear)
         tmr_ff <= 8'h00;
      else if (run)
         tmr_ff <= tmr_ff + 8'h01;
   end
   assign special_event = run && tmr_ff >= PER;
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench of the converter trigger/start control
// Assumes: one wait state apb slave, sample value held by the bench
// Notes: random data from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module testbench
   import adctsc_pkg::*;
;
   logic clk_sys, rst, run, special_event, timer_clear, acquire_on, converting, conversion_done_flag;
   logic pready, pslverr, er_v;
   adctsc_apb_req_t req;
   logic [31:0] prdata, rd_v, rnd;
   logic [9:0] sample_value;
   logic [7:0] tmr;
   logic [3:0] channel_select;
   logic [4:0] tcase [3] = '{5'h1B, 5'h1A, 5'h0B};
   int n_errors = 0;
   int num_checks = 0;
   adctsc_top u_adctsc_top (.clk_sys(clk_sys), .rst(rst), .apb_req(req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .special_event(special_event), .sample_value(sample_value), .timer_clear(timer_clear),
      .acquire_on(acquire_on), .channel_select(channel_select), .converting(converting),
      .conversion_done_flag(conversion_done_flag));
   adctsc_partner u_adctsc_partner (.clk_sys(clk_sys), .rst(rst), .run(run), .timer_clear(timer_clear),
      .special_event(special_event), .tmr_ff(tmr));
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // result pair as {high, low} for right or left justification
   function automatic logic [15:0] res(input logic [9:0] v, input logic right);
      return right ? {6'h00, v} : {v, 6'h00};
   endfunction
   task results;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         chk("pready", 32'h1, 32'h0);
         results;
      end
      rd_v = prdata;
      er_v = pslverr;
      req <= '0;
      @(posedge clk_sys);
   endtask
   task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd_v);
   endtask
   task wait_done;
      int n;
      for (n = 0; n < 2000 && conversion_done_flag !== 1'b1; n++)
         @(posedge clk_sys);
      if (conversion_done_flag !== 1'b1)
      begin
         chk("done_wait", 32'h1, 32'h0);
         results;
      end
   endtask
   initial
   begin
      int i;
      int n_clr;
      logic [15:0] hold;
      req = '0;
      rst = 1'b1;
      run = 1'b0;
      sample_value = '0;
      rnd = 32'd98733;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      for (i = 0; i < 9; i++)
         rdchk("reset", 8'(4 * i), (i == 2) ? 32'h7F : 32'h0);
      apb(1'b0, 8'h24, 32'h0);
      chk("slverr", 32'h1, 32'(er_v));
      for (i = 0; i < 4; i++)
      begin
         rnd = lfsr(rnd);
         apb(1'b1, ADR_REF_PINS, rnd);
         rdchk("ref_pins", ADR_REF_PINS, {24'h0, rnd[7:0] & REF_PINS_MASK});
      end
      $display("test registers done");
      // random clock select and justification, software start
      for (i = 0; i < 4; i++)
      begin
         rnd = lfsr(rnd);
         sample_value <= rnd[25:16];
         apb(1'b1, ADR_FORMAT_CLOCK, {24'h0, rnd[31], 4'h0, rnd[2:0]});
         apb(1'b1, ADR_IRQ_FLAGS, 32'h0);
         apb(1'b1, ADR_CONTROL_MAIN, {26'h0, rnd[7:4], 2'b01});
         chk("channel", 32'(rnd[7:4]), 32'(channel_select));
         repeat (8) @(posedge clk_sys);
         apb(1'b1, ADR_CONTROL_MAIN, {26'h0, rnd[7:4], 2'b11});
         wait_done;
         hold = res(rnd[25:16], rnd[31]);
         rdchk("res_high", ADR_RESULT_HIGH, {24'h0, hold[15:8]});
         rdchk("res_low", ADR_RESULT_LOW, {24'h0, hold[7:0]});
         rdchk("go_clear", ADR_CONTROL_MAIN, {26'h0, rnd[7:4], 2'b01});
      end
      $display("test conversions done");
      // abort in mid conversion must keep the old result
      sample_value <= ~rnd[25:16];
      apb(1'b1, ADR_FORMAT_CLOCK, 32'h0);
      apb(1'b1, ADR_IRQ_FLAGS, 32'h0);
      apb(1'b1, ADR_CONTROL_MAIN, 32'h3);
      repeat (6) @(posedge clk_sys);
      apb(1'b1, ADR_CONTROL_MAIN, 32'h1);
      repeat (30) @(posedge clk_sys);
      chk("abort_flag", 32'h0, 32'(conversion_done_flag));
      rdchk("abort_res", ADR_RESULT_HIGH, {24'h0, hold[15:8]});
      chk("reacquire", 32'h1, 32'(acquire_on));
      $display("test abort done");
      // trigger cases: mode 1011 enabled, wrong mode, disabled
      for (i = 0; i < 3; i++)
      begin
         apb(1'b1, ADR_COMPARE_CTRL, {28'h0, tcase[i][3:0]});
         apb(1'b1, ADR_CONTROL_MAIN, {31'h0, tcase[i][4]});
         apb(1'b1, ADR_IRQ_FLAGS, 32'h0);
         n_clr = 0;
         run <= 1'b1;
         repeat (300)
         begin
            @(posedge clk_sys);
            n_clr += timer_clear;
         end
         run <= 1'b0;
         chk("timer_clear", 32'(tcase[i][3:0] == COMPARE_MODE_TRIGGER), 32'(n_clr != 0));
         chk("trig_done", 32'(tcase[i] == 5'h1B), 32'(conversion_done_flag));
      end
      $display("test triggers done");
      results;
   end
endmodule
`default_nettype wire
